// >>> pcs_cfg.svh
// Constants for the program sequencing and indirect addressing block
//----------------------------------------------------------------------
// Summary of operation
// - Thirteen-bit counter, low byte software visible
// - Upper counter bits not directly writable; loads take them from latch
// - Any reset clears whole program counter
// - Low byte write loads upper five bits from low five latch bits
// - Call/goto takes top two bits from latch
// - Computed jump adds offset, no upper carry
// - Eight-entry stack of thirteen-bit words
// - Stack and pointer hidden from software
// - Call or interrupt vectoring pushes counter
// - Return variants pop stack into counter
// - Push and pop leave latch unchanged
// - Stack is circular; ninth push overwrites first
// - No overflow or underflow status exists
// - Indirect port has no storage, redirects access
// - Self-pointing indirect read returns zero
// - Self-pointing indirect write stores nothing
// - Indirect address is bank bit plus pointer
//----------------------------------------------------------------------
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH
`define PCS_ADR_PC_LOW 32'h00000000
`define PCS_ADR_LATCH 32'h00000004
`define PCS_ADR_POINTER 32'h00000008
`define PCS_ADR_BANK 32'h0000000C
`define PCS_ADR_STACK_PTR 32'h00000010
`define PCS_PC_RESET 13'h0000
`define PCS_LATCH_RESET 8'h00
`define PCS_POINTER_RESET 8'h00
`define PCS_INDIRECT_PORT_ADR 8'h00
`define PCS_INT_VECTOR 13'h0004
`define PCS_STACK_DEPTH 8
`endif

// >>> pcs_pkg.sv
// Types for the program sequencing and indirect addressing block
package pcs_pkg;
   typedef enum logic [3:0] {
      PCS_OP_NONE = 4'h0,
      PCS_OP_STEP = 4'h1,
      PCS_OP_GOTO = 4'h2,
      PCS_OP_CALL = 4'h3,
      PCS_OP_RETURN = 4'h4,
      PCS_OP_RETURN_LIT = 4'h5,
      PCS_OP_RETURN_INT = 4'h6,
      PCS_OP_INT_VECTOR = 4'h7,
      PCS_OP_ADD_LOW = 4'h8
   } pcs_op_type;
   typedef logic [12:0] pcs_pc_type;
endpackage : pcs_pkg

// >>> pcs_core.sv
// Program counter, return stack and indirect address former
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`include "pcs_cfg.svh"
module pcs_core (
   input wire logic clk_i,
   input wire logic rst_i,
   // Classic Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Instruction execution side
   input wire logic op_valid_i,
   input wire logic [3:0] op_i,
   input wire logic [10:0] op_target_i,
   input wire logic [7:0] op_offset_i,
   // Indirect data access from the core
   input wire logic ind_valid_i,
   input wire logic ind_we_i,
   input wire logic [7:0] ind_wdata_i,
   input wire logic [7:0] ind_rdata_mem_i,
   output logic [12:0] pc_o,
   output logic [8:0] ind_addr_o,
   output logic ind_mem_we_o,
   output logic [7:0] ind_mem_wdata_o,
   output logic [7:0] ind_rdata_o
);
   //----------------------------------------------------------------
   // State
   //----------------------------------------------------------------
   logic [12:0] pc_reg;
   logic [12:0] pc_next;
   logic [7:0] pc_upper_holding_latch;
   logic [7:0] pointer_select_reg;
   logic indirect_bank_bit;
   logic [2:0] sp_reg;
   logic [12:0] stack_mem [0:`PCS_STACK_DEPTH-1];
   logic [31:0] rdata_next;
   logic ack_reg;
   logic [8:0] ind_addr_reg;
   logic ind_we_reg;
   logic [7:0] ind_wd_reg;
   logic [7:0] ind_rd_reg;

   // Wrap a stack pointer step modulo eight
   function automatic logic [2:0] sp_step(input logic [2:0] sp, input logic up);
      sp_step = up ? sp + 3'h1 : sp - 3'h1;
   endfunction : sp_step

   //----------------------------------------------------------------
   // Decode
   //----------------------------------------------------------------
   wire bus_req = cyc_i && stb_i && !ack_reg;
   wire bus_wr = bus_req && we_i && sel_i[0];
   wire wr_low = bus_wr && (adr_i == `PCS_ADR_PC_LOW);
   wire wr_latch = bus_wr && (adr_i == `PCS_ADR_LATCH);
   wire wr_ptr = bus_wr && (adr_i == `PCS_ADR_POINTER);
   wire wr_bank = bus_wr && (adr_i == `PCS_ADR_BANK);
   wire op_go = op_valid_i && !wr_low;
   wire is_push = op_go && (op_i == pcs_pkg::PCS_OP_CALL || op_i == pcs_pkg::PCS_OP_INT_VECTOR);
   wire is_pop = op_go && (op_i == pcs_pkg::PCS_OP_RETURN || op_i == pcs_pkg::PCS_OP_RETURN_LIT
                           || op_i == pcs_pkg::PCS_OP_RETURN_INT);
   wire [2:0] sp_pop = sp_step(sp_reg, 1'b0);
   wire [12:0] pc_inc = pc_reg + 13'h0001;
   wire [8:0] ind_addr = {indirect_bank_bit, pointer_select_reg};
   wire ind_self = (pointer_select_reg == `PCS_INDIRECT_PORT_ADR);

   // Next program counter
   always_comb begin
      pc_next = pc_reg;
      if (wr_low) begin
         pc_next = {pc_upper_holding_latch[4:0], dat_i[7:0]};
      end else if (op_valid_i) begin
         case (pcs_pkg::pcs_op_type'(op_i))
            pcs_pkg::PCS_OP_STEP: pc_next = pc_inc;
            pcs_pkg::PCS_OP_GOTO,
            pcs_pkg::PCS_OP_CALL: pc_next = {pc_upper_holding_latch[4:3], op_target_i};
            pcs_pkg::PCS_OP_RETURN,
            pcs_pkg::PCS_OP_RETURN_LIT,
            pcs_pkg::PCS_OP_RETURN_INT: pc_next = stack_mem[sp_pop];
            pcs_pkg::PCS_OP_INT_VECTOR: pc_next = `PCS_INT_VECTOR;
            // Low byte only; no carry into upper bits
            pcs_pkg::PCS_OP_ADD_LOW: pc_next = {pc_upper_holding_latch[4:0],
                                                 pc_reg[7:0] + op_offset_i};
            default: pc_next = pc_reg;
         endcase
      end
   end

   // Program counter register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_reg <= `PCS_PC_RESET;
      end else begin
         pc_reg <= pc_next;
      end
   end

   // Return stack, circular with wrapping pointer, no status flags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sp_reg <= 3'h0;
      end else if (is_push) begin
         stack_mem[sp_reg] <= (op_i == pcs_pkg::PCS_OP_CALL) ? pc_inc : pc_reg;
         sp_reg <= sp_step(sp_reg, 1'b1);
      end else if (is_pop) begin
         sp_reg <= sp_pop;
      end
   end

   // Software registers; latch untouched by stack operations
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_upper_holding_latch <= `PCS_LATCH_RESET;
         pointer_select_reg <= `PCS_POINTER_RESET;
         indirect_bank_bit <= 1'b0;
      end else begin
         if (wr_latch) pc_upper_holding_latch <= dat_i[7:0];
         if (wr_ptr) pointer_select_reg <= dat_i[7:0];
         if (wr_bank) indirect_bank_bit <= dat_i[0];
      end
   end

   // Read mux; stack pointer deliberately not visible
   always_comb begin
      rdata_next = 32'h00000000;
      case (adr_i)
         `PCS_ADR_PC_LOW: rdata_next = {24'h000000, pc_reg[7:0]};
         `PCS_ADR_LATCH: rdata_next = {24'h000000, pc_upper_holding_latch};
         `PCS_ADR_POINTER: rdata_next = {24'h000000, pointer_select_reg};
         `PCS_ADR_BANK: rdata_next = {31'h00000000, indirect_bank_bit};
         default: rdata_next = 32'h00000000;
      endcase
   end

   // Bus answer one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_reg <= bus_req;
         dat_o <= bus_req ? rdata_next : 32'h00000000;
      end
   end

   // Indirect access redirected through the pointer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ind_addr_reg <= 9'h000;
         ind_we_reg <= 1'b0;
         ind_wd_reg <= 8'h00;
         ind_rd_reg <= 8'h00;
      end else begin
         ind_addr_reg <= ind_addr;
         ind_we_reg <= ind_valid_i && ind_we_i && !ind_self;
         ind_wd_reg <= ind_wdata_i;
         ind_rd_reg <= ind_self ? 8'h00 : ind_rdata_mem_i;
      end
   end

   assign ack_o = ack_reg;
   assign pc_o = pc_reg;
   assign ind_addr_o = ind_addr_reg;
   assign ind_mem_we_o = ind_we_reg;
   assign ind_mem_wdata_o = ind_wd_reg;
   assign ind_rdata_o = ind_rd_reg;

   //----------------------------------------------------------------
   // Assertions
   //----------------------------------------------------------------
   // Reset empties the counter
   AST_RESET_CLEARS: assert property (@(posedge clk_i) rst_i |=> pc_reg == 13'h0000)
      else $error("pc not cleared by reset");

   // Low byte write takes upper bits from latch
   AST_LOW_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_low |=> pc_reg == {$past(pc_upper_holding_latch[4:0]), $past(dat_i[7:0])})
      else $error("low byte write load wrong");

   // Call takes top two bits from latch
   AST_CALL_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
      is_push && op_i == pcs_pkg::PCS_OP_CALL
      |=> pc_reg[12:11] == $past(pc_upper_holding_latch[4:3]))
      else $error("call upper bits wrong");

   // Goto loads latch bits and target
   AST_GOTO_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
      op_go && op_i == pcs_pkg::PCS_OP_GOTO
      |=> pc_reg == {$past(pc_upper_holding_latch[4:3]), $past(op_target_i)})
      else $error("goto load wrong");

   // Return right after call resumes after the call
   AST_CALL_RETURN: assert property (@(posedge clk_i) disable iff (rst_i)
      is_push && op_i == pcs_pkg::PCS_OP_CALL ##1 (is_pop && !is_push)
      |=> pc_reg == $past(pc_reg, 2) + 13'h0001)
      else $error("return address wrong");

   // Any pop loads the entry below the pointer
   AST_POP_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
      is_pop |=> pc_reg == $past(stack_mem[sp_pop]))
      else $error("pop load wrong");

   // Call pushes the address after itself
   AST_CALL_PUSH: assert property (@(posedge clk_i) disable iff (rst_i)
      is_push && op_i == pcs_pkg::PCS_OP_CALL
      |=> stack_mem[$past(sp_reg)] == $past(pc_reg) + 13'h0001)
      else $error("call push value wrong");

   // Interrupt pushes the current counter
   AST_VECTOR_PUSH: assert property (@(posedge clk_i) disable iff (rst_i)
      is_push && op_i == pcs_pkg::PCS_OP_INT_VECTOR
      |=> stack_mem[$past(sp_reg)] == $past(pc_reg) && pc_reg == `PCS_INT_VECTOR)
      else $error("interrupt push wrong");

   // Plain step advances by one
   AST_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
      op_go && op_i == pcs_pkg::PCS_OP_STEP |=> pc_reg == $past(pc_reg) + 13'h0001)
      else $error("step wrong");

   // Computed jump keeps the carry out of the upper bits
   AST_ADD_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
      op_go && op_i == pcs_pkg::PCS_OP_ADD_LOW
      |=> pc_reg[7:0] == $past(pc_reg[7:0]) + $past(op_offset_i)
          && pc_reg[12:8] == $past(pc_upper_holding_latch[4:0]))
      else $error("computed jump wrong");

   // Counter holds without an instruction or low write
   AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      !op_valid_i && !wr_low |=> $stable(pc_reg))
      else $error("counter moved while idle");

   // Pointer wraps upward
   AST_PUSH_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
      is_push |=> sp_reg == $past(sp_reg) + 3'h1)
      else $error("stack pointer not advanced");

   // Pointer wraps downward
   AST_POP_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
      is_pop |=> sp_reg == $past(sp_reg) - 3'h1)
      else $error("stack pointer not retreated");

   // Stack traffic leaves the latch alone
   AST_LATCH_KEPT: assert property (@(posedge clk_i) disable iff (rst_i)
      (is_push || is_pop) && !wr_latch |=> $stable(pc_upper_holding_latch))
      else $error("latch moved by stack op");

   // Hidden pointer reads back as zero
   AST_HIDDEN_READ: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_req && !we_i && adr_i == `PCS_ADR_STACK_PTR |=> dat_o == 32'h00000000)
      else $error("hidden location not zero");

   // Self-pointing read yields zero
   AST_SELF_READ: assert property (@(posedge clk_i) disable iff (rst_i)
      ind_self |=> ind_rdata_o == 8'h00)
      else $error("self indirect read not zero");

   // Self-pointing write stores nothing
   AST_SELF_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      ind_self |=> !ind_mem_we_o)
      else $error("self indirect write stored");

   // Other writes pass through to memory
   AST_IND_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      ind_valid_i && ind_we_i && !ind_self
      |=> ind_mem_we_o && ind_mem_wdata_o == $past(ind_wdata_i))
      else $error("indirect write not passed");

   // Other reads return memory data
   AST_IND_READ: assert property (@(posedge clk_i) disable iff (rst_i)
      !ind_self |=> ind_rdata_o == $past(ind_rdata_mem_i))
      else $error("indirect read not passed");

   // Address is bank bit over pointer
   AST_IND_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
      1'b1 |=> ind_addr_o == {$past(indirect_bank_bit), $past(pointer_select_reg)})
      else $error("indirect address wrong");

   //----------------------------------------------------------------
   // Coverage
   //----------------------------------------------------------------
   COV_CALL_RET: cover property (@(posedge clk_i) is_push ##[1:20] is_pop);
   COV_WRAP: cover property (@(posedge clk_i) is_push && sp_reg == 3'h7);
   COV_LOW_WRITE: cover property (@(posedge clk_i) wr_low);
   COV_SELF: cover property (@(posedge clk_i) ind_valid_i && ind_self);
   COV_VECTOR: cover property (@(posedge clk_i) is_push && op_i == pcs_pkg::PCS_OP_INT_VECTOR);
endmodule : pcs_core

// >>> pcs_mem_model.sv
// Data memory model reached through the indirect port
`timescale 1ns/10ps
module pcs_mem_model (
   input wire logic clk_i,
   input wire logic ind_valid_i,
   input wire logic [8:0] look_adr_i,
   input wire logic [8:0] ind_addr_i,
   input wire logic ind_we_i,
   input wire logic [7:0] ind_wdata_i,
   output logic [7:0] ind_rdata_o
);
   logic [7:0] mem [0:511];
   // Marker fill so a forced zero read stands out
   initial for (int i = 0; i < 512; i++) mem[i] = 8'hC3;
   // Store what the port redirects here
   always @(posedge clk_i) if (ind_we_i) mem[ind_addr_i] <= ind_wdata_i;
   // Inverted contents outside an access
   assign ind_rdata_o = ind_valid_i ? mem[look_adr_i] : ~mem[look_adr_i];
endmodule : pcs_mem_model

// >>> test_pc_stack_indirect_addr.sv
// Self-checking bench for the sequencing and indirect block
`timescale 1ns/10ps
module test_pc_stack_indirect_addr;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, ind_mem_we_o;
   logic op_valid_i = 0, ind_valid_i = 0, ind_we_i = 0;
   logic [31:0] adr_i = 0, dat_i = 0, dat_o, rs = 32'hD8422CBA;
   logic [3:0] sel_i = 4'hF, op_i = 0;
   logic [10:0] op_target_i = 0;
   logic [7:0] op_offset_i = 0, ind_wdata_i = 0, ind_rdata_mem_i, ind_mem_wdata_o, ind_rdata_o;
   logic [7:0] lat = 8'h1A, v;
   logic [7:0] q [$];
   logic [12:0] pc_o, pc, sk [8];
   logic [8:0] ind_addr_o, look = 0;
   logic [2:0] sp = 0;
   int n_errors = 0, n_checks = 0;
   always #12.5 clk_i = ~clk_i;
   pcs_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .op_valid_i(op_valid_i), .op_i(op_i), .op_target_i(op_target_i),
      .op_offset_i(op_offset_i), .ind_valid_i(ind_valid_i), .ind_we_i(ind_we_i),
      .ind_wdata_i(ind_wdata_i), .ind_rdata_mem_i(ind_rdata_mem_i), .pc_o(pc_o),
      .ind_addr_o(ind_addr_o), .ind_mem_we_o(ind_mem_we_o),
      .ind_mem_wdata_o(ind_mem_wdata_o), .ind_rdata_o(ind_rdata_o));
   pcs_mem_model mem_u (.clk_i(clk_i), .ind_valid_i(ind_valid_i), .look_adr_i(look),
      .ind_addr_i(ind_addr_o), .ind_we_i(ind_mem_we_o), .ind_wdata_i(ind_mem_wdata_o),
      .ind_rdata_o(ind_rdata_mem_i));
   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : xs
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Classic cycle; for reads d is the expected byte
   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int t;
      if (!w) q.push_back(d[7:0]);
      @(posedge clk_i);
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      t = 0;
      do begin
         @(posedge clk_i);
         t++;
      end while (ack_o !== 1'b1 && t < 50);
      if (t >= 50) chk(0, 1);
      cyc_i <= 0;
      stb_i <= 0;
   endtask : wb
   // Read data checked against the oldest note
   always @(posedge clk_i) if (ack_o === 1'b1 && we_i === 1'b0) chk(dat_o[7:0], q.pop_front());
   task automatic op(input logic [3:0] o, input logic [10:0] tg, input logic [7:0] of);
      @(posedge clk_i);
      op_valid_i <= 1;
      op_i <= o;
      op_target_i <= tg;
      op_offset_i <= of;
      @(posedge clk_i);
      op_valid_i <= 0;
      case (o)
         pcs_pkg::PCS_OP_STEP: pc = pc + 1;
         pcs_pkg::PCS_OP_GOTO: pc = {lat[4:3], tg};
         pcs_pkg::PCS_OP_CALL: begin
            sk[sp] = pc + 1;
            sp++;
            pc = {lat[4:3], tg};
         end
         pcs_pkg::PCS_OP_INT_VECTOR: begin
            sk[sp] = pc;
            sp++;
            pc = 13'h0004;
         end
         pcs_pkg::PCS_OP_ADD_LOW: pc = {lat[4:0], pc[7:0] + of};
         default: begin
            sp--;
            pc = sk[sp];
         end
      endcase
      @(negedge clk_i);
      chk(pc_o, pc);
   endtask : op
   task automatic ind(input logic w, input logic [7:0] d, input logic [7:0] e);
      @(posedge clk_i);
      ind_valid_i <= 1;
      ind_we_i <= w;
      ind_wdata_i <= d;
      @(posedge clk_i);
      ind_valid_i <= 0;
      @(negedge clk_i);
      chk(ind_addr_o, look);
      chk(ind_mem_we_o, w && look[7:0] != 0);
      if (w) chk(ind_mem_wdata_o, d);
      else chk(ind_rdata_o, e);
   endtask : ind
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   initial begin
      #(25 * 4000);
      n_errors++;
      close_out();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      @(negedge clk_i);
      pc = 0;
      chk(pc_o, pc);
      wb(1, 32'h4, lat);
      wb(0, 32'h10, 0);
      wb(1, 32'h0, 32'h55);
      pc = {lat[4:0], 8'h55};
      @(negedge clk_i);
      chk(pc_o, pc);
      wb(0, 32'h0, 32'h55);
      op(pcs_pkg::PCS_OP_STEP, 0, 0);
      op(pcs_pkg::PCS_OP_GOTO, 11'(xs()), 0);
      for (int i = 0; i < 9; i++) op(pcs_pkg::PCS_OP_CALL, 11'(xs()), 0);
      for (int i = 0; i < 9; i++) op(4'(pcs_pkg::PCS_OP_RETURN + i % 3), 0, 0);
      wb(0, 32'h4, lat);
      op(pcs_pkg::PCS_OP_INT_VECTOR, 0, 0);
      op(pcs_pkg::PCS_OP_RETURN_INT, 0, 0);
      // Call and return on adjacent edges
      @(posedge clk_i);
      op_valid_i <= 1;
      op_i <= pcs_pkg::PCS_OP_CALL;
      op_target_i <= 11'h2A5;
      @(posedge clk_i);
      op_i <= pcs_pkg::PCS_OP_RETURN;
      @(posedge clk_i);
      op_valid_i <= 0;
      pc = pc + 13'h0001;
      @(negedge clk_i);
      chk(pc_o, pc);
      wb(1, 32'h0, 32'hC0);
      pc = {lat[4:0], 8'hC0};
      op(pcs_pkg::PCS_OP_ADD_LOW, 0, 8'h50);
      look = 9'h133;
      wb(1, 32'hC, 1);
      wb(1, 32'h8, 32'h33);
      v = 8'(xs());
      ind(1, v, 0);
      ind(0, 0, v);
      look = 9'h100;
      wb(1, 32'h8, 0);
      ind(1, v, 0);
      ind(0, 0, 0);
      close_out();
   end
endmodule : test_pc_stack_indirect_addr
